// ### verilog/strap_reset_pkg.sv
// Package: register map, field positions, reset values and timing for the strap and reset block
package strap_reset_pkg;

  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned GPIO_N           = 11;
  localparam int unsigned DS_PORTS         = 4;

  // Register byte offsets
  localparam logic [7:0] OFF_SWITCH_CTL    = 8'h00;
  localparam logic [7:0] OFF_STRAP_STAT    = 8'h04;
  localparam logic [7:0] OFF_WAKE_CTL      = 8'h08;
  localparam logic [7:0] OFF_LINK_STAT_US  = 8'h0C;
  localparam logic [7:0] OFF_LINK_STAT_DS  = 8'h10;
  localparam logic [7:0] OFF_GPIO_OUT      = 8'h14;
  localparam logic [7:0] OFF_GPIO_DIR      = 8'h18;
  localparam logic [7:0] OFF_GPIO_ALT      = 8'h1C;
  localparam logic [7:0] OFF_GPIO_IN       = 8'h20;
  localparam logic [7:0] OFF_IRQ_STAT      = 8'h24;
  localparam logic [7:0] OFF_IRQ_EN        = 8'h28;
  localparam logic [7:0] OFF_IRQ_CLR       = 8'h2C;
  localparam logic [7:0] OFF_PORT_RESET    = 8'h30;

  // Switch control fields
  localparam int unsigned SWCTL_HALT_BIT   = 0;
  localparam int unsigned SWCTL_EVENT_BIT  = 1;

  // Wake control fields
  localparam int unsigned WAKE_DIR_BIT     = 0;
  localparam int unsigned WAKE_OUT_BIT     = 1;

  // Slot clock configuration bit inside a link status register
  localparam int unsigned SLOT_CLK_BIT     = 12;

  // Strap status fields
  localparam int unsigned ST_EEPROM_LSB    = 0;
  localparam int unsigned ST_SLAVE_LSB     = 8;
  localparam int unsigned ST_MODE_LSB      = 16;
  localparam int unsigned ST_SLOW_BIT      = 20;
  localparam int unsigned ST_EELOAD_BIT    = 21;
  localparam int unsigned ST_RSVD_BIT      = 22;
  localparam int unsigned ST_AUXDIS_BIT    = 23;
  localparam int unsigned ST_HOLD_BIT      = 24;

  // Interrupt status bits
  localparam int unsigned IRQ_EXP0_BIT     = 0;
  localparam int unsigned IRQ_WAKE_BIT     = 3;
  localparam int unsigned IRQ_HOLD_BIT     = 4;
  localparam int unsigned IRQ_W            = 5;

  // Alternate-function pin indices
  localparam int unsigned PIN_P2RST        = 0;
  localparam int unsigned PIN_P4RST        = 1;
  localparam int unsigned PIN_EXP0         = 2;
  localparam int unsigned PIN_EXP1         = 3;
  localparam int unsigned PIN_EXP2         = 4;
  localparam int unsigned PIN_EVENT        = 7;
  localparam int unsigned PIN_P3RST        = 9;
  localparam int unsigned PIN_P5RST        = 10;

  // Switch mode codes
  localparam logic [2:0] MODE_NORMAL       = 3'h0;
  localparam logic [2:0] MODE_EEPROM       = 3'h1;

  // Reset values
  localparam logic [10:0] GPIO_ALT_RST     = 11'h000;
  localparam logic [10:0] GPIO_DIR_RST     = 11'h000;
  localparam logic [10:0] GPIO_OUT_RST     = 11'h000;

  // Master bus rates
  localparam int unsigned SLOW_KHZ         = 100;
  localparam int unsigned FAST_KHZ         = 400;
  localparam int unsigned SLOW_DIV         = (CLK_MHZ * 1000) / SLOW_KHZ;
  localparam int unsigned FAST_DIV         = (CLK_MHZ * 1000) / FAST_KHZ;

  // Hold time of the internal fundamental-reset procedure
  localparam int unsigned RESET_PROC_NS    = 400;
  localparam int unsigned RESET_PROC_CYC   = (RESET_PROC_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic [3:0] eeprom_addr;
    logic [3:0] slave_addr;
    logic [2:0] mode;
    logic       slow;
    logic       cclk_ds;
    logic       cclk_us;
    logic       hold;
  } straps_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage

// ### verilog/mgmt_rate_div.sv
// Module: master management bus bit-rate enable divider
`timescale 1ns/1ps
`default_nettype none
module mgmt_rate_div
  import strap_reset_pkg::*;
#(
  parameter int unsigned SLOW_CNT = SLOW_DIV,
  parameter int unsigned FAST_CNT = FAST_DIV
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic slow_i,
  output logic      tick_o
);
  localparam int unsigned CW = $clog2(SLOW_CNT + 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] lim;

  // Rate is fixed by the strap only
  assign lim = slow_i ? CW'(SLOW_CNT - 1) : CW'(FAST_CNT - 1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_r >= lim) begin
      cnt_r  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + CW'(1);
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verilog/pin_mux.sv
// Module: per-pin general-purpose and alternate-function multiplexer
`timescale 1ns/1ps
`default_nettype none
module pin_mux
  import strap_reset_pkg::*;
#(
  parameter int unsigned N = GPIO_N
) (
  input  wire logic [N-1:0] alt_i,
  input  wire logic [N-1:0] alt_out_i,
  input  wire logic [N-1:0] alt_oe_i,
  input  wire logic [N-1:0] gp_out_i,
  input  wire logic [N-1:0] gp_dir_i,
  output logic      [N-1:0] pin_nxt_o,
  output logic      [N-1:0] oe_nxt_o
);
  for (genvar i = 0; i < N; i++) begin : g_pin
    // Alternate output wins over the general-purpose register
    assign pin_nxt_o[i] = alt_i[i] ? alt_out_i[i] : gp_out_i[i];
    assign oe_nxt_o[i]  = alt_i[i] ? alt_oe_i[i]  : gp_dir_i[i];
  end
endmodule
`default_nettype wire

// ### verilog/switch_strap_reset_control.sv
// Module: strap capture, fundamental reset, hold-off, wake and general-purpose pin control
//
// Overview of operation
// - EEPROM bus address bits 4:1 come from four address straps.
// - Slave bus answers only its strap address, bits 5 and 3:1.
// - Slow strap selects 100 kHz master bus, else 400 kHz; no override.
// - Downstream common-clock strap loads every downstream slot clock bit at reset.
// - Upstream common-clock strap loads upstream slot clock bit at reset.
// - Fundamental reset clears all logic and starts a link fundamental reset.
// - Hold request at reset keeps device in reset until halt bit cleared.
// - Mode 0 normal, 1 normal with EEPROM load, 2 and above reserved.
// - Wake pin direction follows the wake control direction bit.
// - Auxiliary power is unused while the disable input is active.
// - Each of eleven pins can act as a general-purpose I/O.
// - Pins 0,1,9,10 drive low-active resets for ports 2,4,3,5.
// - Pins 2,3,4 take low-active expander interrupts 0,1,2.
// - Pin 7 drives the low-active general purpose event output.
// - Names ending _n, and resetn_i, are asserted low, all others high.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module switch_strap_reset_control
  import strap_reset_pkg::*;
#(
  parameter int unsigned N         = GPIO_N,
  parameter int unsigned PROC_CYC  = RESET_PROC_CYC
) (
  input  wire logic          mclk_i,
  input  wire logic          resetn_i,
  // APB slave
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [7:0]    paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic      [31:0]   prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  // Straps
  input  wire logic [3:0]    eeprom_addr_strap_i,
  input  wire logic [3:0]    slave_bus_addr_strap_i,
  input  wire logic [2:0]    switch_mode_strap_i,
  input  wire logic          master_bus_slow_strap_i,
  input  wire logic          common_clock_downstream_strap_i,
  input  wire logic          common_clock_upstream_strap_i,
  input  wire logic          reset_hold_request_i,
  input  wire logic          aux_power_disable_n_i,
  // Wake pin
  input  wire logic          wake_pin_n_i,
  output logic               wake_pin_n_o,
  output logic               wake_pin_n_oe_o,
  // General-purpose pins
  input  wire logic [N-1:0]  gpio_i,
  output logic      [N-1:0]  gpio_o,
  output logic      [N-1:0]  gpio_oe_o,
  // Derived outputs
  output logic      [6:0]    eeprom_bus_addr_o,
  output logic      [6:0]    slave_bus_addr_o,
  output logic               master_bus_tick_o,
  output logic               eeprom_load_o,
  output logic               mode_reserved_o,
  output logic               aux_power_en_o,
  output logic               link_fund_reset_o,
  output logic               device_in_reset_o,
  output logic               irq_o
);

  // Reset release synchroniser
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // Strap capture: tracks pins while reset is low, freezes after release
  straps_s strap_r;
  logic    strap_done_r;
  always_ff @(posedge mclk_i) begin
    if (!rst_n && !strap_done_r) begin
      strap_r.eeprom_addr <= eeprom_addr_strap_i;
      strap_r.slave_addr  <= slave_bus_addr_strap_i;
      strap_r.mode        <= switch_mode_strap_i;
      strap_r.slow        <= master_bus_slow_strap_i;
      strap_r.cclk_ds     <= common_clock_downstream_strap_i;
      strap_r.cclk_us     <= common_clock_upstream_strap_i;
      strap_r.hold        <= reset_hold_request_i;
    end
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_done_r <= 1'b0;
    end else if (rst_n) begin
      strap_done_r <= 1'b1;
    end
  end

  // Reset procedure sequencer
  typedef enum logic [2:0] {
    ST_PROC = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN  = 3'b100
  } seq_e;
  localparam int unsigned PW = $clog2(PROC_CYC + 1);
  seq_e          state_r;
  logic [PW-1:0] proc_cnt_r;
  logic          halt_r;
  logic          apb_wr;
  logic          hold_rel;
  assign apb_wr   = psel_i && penable_i && pwrite_i;
  assign hold_rel = apb_wr && paddr_i == OFF_SWITCH_CTL && !pwdata_i[SWCTL_HALT_BIT];

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_PROC;
      proc_cnt_r <= '0;
    end else begin
      unique case (state_r)
        ST_PROC: begin
          if (proc_cnt_r == PW'(PROC_CYC - 1)) begin
            state_r <= halt_r ? ST_HOLD : ST_RUN;
          end else begin
            proc_cnt_r <= proc_cnt_r + PW'(1);
          end
        end
        ST_HOLD: begin
          if (!halt_r) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: ;
      endcase
    end
  end

  // Halt bit: loaded from the hold strap, cleared only by software
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      halt_r <= 1'b0;
    end else if (state_r == ST_PROC && proc_cnt_r == '0) begin
      halt_r <= strap_r.hold;
    end else if (hold_rel) begin
      halt_r <= 1'b0;
    end
  end

  // Software registers
  logic           wake_dir_r;
  logic           wake_out_r;
  logic           event_r;
  logic           slot_us_r;
  logic [DS_PORTS-1:0] slot_ds_r;
  logic [DS_PORTS-1:0] port_rst_r;
  logic [N-1:0]   gp_out_r;
  logic [N-1:0]   gp_dir_r;
  logic [N-1:0]   gp_alt_r;
  logic           slot_loaded_r;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_dir_r    <= 1'b0;
      wake_out_r    <= 1'b0;
      event_r       <= 1'b0;
      gp_out_r      <= GPIO_OUT_RST;
      gp_dir_r      <= GPIO_DIR_RST;
      gp_alt_r      <= GPIO_ALT_RST;
      port_rst_r    <= '1;
    end else if (apb_wr) begin
      unique case (paddr_i)
        OFF_SWITCH_CTL: event_r <= pwdata_i[SWCTL_EVENT_BIT];
        OFF_WAKE_CTL: begin
          wake_dir_r <= pwdata_i[WAKE_DIR_BIT];
          wake_out_r <= pwdata_i[WAKE_OUT_BIT];
        end
        OFF_GPIO_OUT:   gp_out_r   <= pwdata_i[N-1:0];
        OFF_GPIO_DIR:   gp_dir_r   <= pwdata_i[N-1:0];
        OFF_GPIO_ALT:   gp_alt_r   <= pwdata_i[N-1:0];
        OFF_PORT_RESET: port_rst_r <= pwdata_i[DS_PORTS-1:0];
        default: ;
      endcase
    end
  end

  // Slot clock bits take strap values once after reset, then software owns them
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      slot_us_r     <= 1'b0;
      slot_ds_r     <= '0;
      slot_loaded_r <= 1'b0;
    end else if (!slot_loaded_r) begin
      slot_loaded_r <= 1'b1;
      slot_us_r     <= strap_r.cclk_us;
      slot_ds_r     <= {DS_PORTS{strap_r.cclk_ds}};
    end else if (apb_wr && paddr_i == OFF_LINK_STAT_US) begin
      slot_us_r <= pwdata_i[SLOT_CLK_BIT];
    end else if (apb_wr && paddr_i == OFF_LINK_STAT_DS) begin
      slot_ds_r <= pwdata_i[SLOT_CLK_BIT +: DS_PORTS];
    end
  end

  // Interrupt status: expander, wake input, hold release
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;
  logic             wake_in_d_r;

  always_comb begin
    irq_evt = '0;
    // Expander interrupts are low-active levels on alternate pins
    irq_evt[IRQ_EXP0_BIT +: 3] = gp_alt_r[PIN_EXP0 +: 3] & ~gpio_i[PIN_EXP0 +: 3];
    irq_evt[IRQ_WAKE_BIT] = !wake_dir_r && wake_in_d_r && !wake_pin_n_i;
    irq_evt[IRQ_HOLD_BIT] = state_r == ST_HOLD && !halt_r;
    irq_clr = (apb_wr && paddr_i == OFF_IRQ_CLR) ? pwdata_i[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r  <= '0;
      irq_en_r    <= '0;
      wake_in_d_r <= 1'b1;
    end else begin
      wake_in_d_r <= wake_pin_n_i;
      // Set beats clear in the same cycle
      irq_stat_r  <= (irq_stat_r & ~irq_clr) | irq_evt;
      if (apb_wr && paddr_i == OFF_IRQ_EN) begin
        irq_en_r <= pwdata_i[IRQ_W-1:0];
      end
    end
  end

  // Pin multiplexing
  logic [N-1:0] alt_out;
  logic [N-1:0] alt_oe;
  logic [N-1:0] pin_nxt;
  logic [N-1:0] oe_nxt;
  logic         in_reset;

  assign in_reset = state_r != ST_RUN;

  always_comb begin
    alt_out = '1;
    alt_oe  = '0;
    // Downstream port resets are held asserted while the device is in reset
    alt_out[PIN_P2RST] = !(in_reset || port_rst_r[0]);
    alt_out[PIN_P4RST] = !(in_reset || port_rst_r[1]);
    alt_out[PIN_P3RST] = !(in_reset || port_rst_r[2]);
    alt_out[PIN_P5RST] = !(in_reset || port_rst_r[3]);
    alt_out[PIN_EVENT] = !event_r;
    alt_oe[PIN_P2RST]  = 1'b1;
    alt_oe[PIN_P4RST]  = 1'b1;
    alt_oe[PIN_P3RST]  = 1'b1;
    alt_oe[PIN_P5RST]  = 1'b1;
    alt_oe[PIN_EVENT]  = 1'b1;
  end

  pin_mux #(.N(N)) u_pin_mux (
    .alt_i     (gp_alt_r),
    .alt_out_i (alt_out),
    .alt_oe_i  (alt_oe),
    .gp_out_i  (gp_out_r),
    .gp_dir_i  (gp_dir_r),
    .pin_nxt_o (pin_nxt),
    .oe_nxt_o  (oe_nxt)
  );

  logic tick;
  mgmt_rate_div u_rate (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n),
    .slow_i  (strap_r.slow),
    .tick_o  (tick)
  );

  // Registered outputs
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      gpio_o            <= '1;
      gpio_oe_o         <= '0;
      wake_pin_n_o      <= 1'b1;
      wake_pin_n_oe_o   <= 1'b0;
      eeprom_bus_addr_o <= '0;
      slave_bus_addr_o  <= '0;
      master_bus_tick_o <= 1'b0;
      eeprom_load_o     <= 1'b0;
      mode_reserved_o   <= 1'b0;
      aux_power_en_o    <= 1'b0;
      link_fund_reset_o <= 1'b1;
      device_in_reset_o <= 1'b1;
      irq_o             <= 1'b0;
    end else begin
      gpio_o            <= pin_nxt;
      gpio_oe_o         <= oe_nxt;
      wake_pin_n_o      <= !wake_out_r;
      wake_pin_n_oe_o   <= wake_dir_r;
      eeprom_bus_addr_o <= {2'b10, strap_r.eeprom_addr, 1'b0};
      slave_bus_addr_o  <= {1'b1, strap_r.slave_addr[3], 1'b1,
                            strap_r.slave_addr[2:0], 1'b0};
      master_bus_tick_o <= tick;
      eeprom_load_o     <= strap_r.mode == MODE_EEPROM;
      mode_reserved_o   <= strap_r.mode > MODE_EEPROM;
      aux_power_en_o    <= aux_power_disable_n_i;
      link_fund_reset_o <= state_r == ST_PROC;
      device_in_reset_o <= in_reset;
      irq_o             <= |(irq_stat_r & irq_en_r);
    end
  end

  // APB read and answer; zero wait states, unmapped address flags an error
  logic [31:0] rd_nxt;
  logic        hit;
  always_comb begin
    rd_nxt = '0;
    hit    = 1'b1;
    unique case (paddr_i)
      OFF_SWITCH_CTL: begin
        rd_nxt[SWCTL_HALT_BIT]  = halt_r;
        rd_nxt[SWCTL_EVENT_BIT] = event_r;
      end
      OFF_STRAP_STAT: begin
        rd_nxt[ST_EEPROM_LSB +: 4] = strap_r.eeprom_addr;
        rd_nxt[ST_SLAVE_LSB +: 4]  = strap_r.slave_addr;
        rd_nxt[ST_MODE_LSB +: 3]   = strap_r.mode;
        rd_nxt[ST_SLOW_BIT]        = strap_r.slow;
        rd_nxt[ST_EELOAD_BIT]      = strap_r.mode == MODE_EEPROM;
        rd_nxt[ST_RSVD_BIT]        = strap_r.mode > MODE_EEPROM;
        rd_nxt[ST_AUXDIS_BIT]      = !aux_power_disable_n_i;
        rd_nxt[ST_HOLD_BIT]        = state_r == ST_HOLD;
      end
      OFF_WAKE_CTL: begin
        rd_nxt[WAKE_DIR_BIT] = wake_dir_r;
        rd_nxt[WAKE_OUT_BIT] = wake_dir_r ? wake_out_r : !wake_pin_n_i;
      end
      OFF_LINK_STAT_US: rd_nxt[SLOT_CLK_BIT] = slot_us_r;
      OFF_LINK_STAT_DS: rd_nxt[SLOT_CLK_BIT +: DS_PORTS] = slot_ds_r;
      OFF_GPIO_OUT:     rd_nxt[N-1:0] = gp_out_r;
      OFF_GPIO_DIR:     rd_nxt[N-1:0] = gp_dir_r;
      OFF_GPIO_ALT:     rd_nxt[N-1:0] = gp_alt_r;
      OFF_GPIO_IN:      rd_nxt[N-1:0] = gpio_i;
      OFF_IRQ_STAT:     rd_nxt[IRQ_W-1:0] = irq_stat_r;
      OFF_IRQ_EN:       rd_nxt[IRQ_W-1:0] = irq_en_r;
      OFF_IRQ_CLR:      rd_nxt = '0;
      OFF_PORT_RESET:   rd_nxt[DS_PORTS-1:0] = port_rst_r;
      default:          hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o  <= '0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !hit;
      if (psel_i && !penable_i) begin
        prdata_o <= pwrite_i ? '0 : rd_nxt;
      end
    end
  end

endmodule
`default_nettype wire

// ### testbench/strap_reset_monitor.sv
// Checker: port-level timing of the strap and reset block
`timescale 1ns/1ps
`default_nettype none
module strap_reset_monitor
  import strap_reset_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        master_bus_slow_strap_i,
  input wire logic        aux_power_disable_n_i,
  input wire logic [6:0]  eeprom_bus_addr_o,
  input wire logic [6:0]  slave_bus_addr_o,
  input wire logic        master_bus_tick_o,
  input wire logic        aux_power_en_o,
  input wire logic        link_fund_reset_o,
  input wire logic        device_in_reset_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic [15:0] gap_r;
  logic        seen_r;
  // Cycles since the last bit-rate tick
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_r  <= 16'h0000;
      seen_r <= 1'b0;
    end else if (master_bus_tick_o) begin
      gap_r  <= 16'h0001;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 16'h0001;
    end
  end
  sequence halt_clear_s;
    psel_i && penable_i && pwrite_i && paddr_i == OFF_SWITCH_CTL &&
    !pwdata_i[SWCTL_HALT_BIT] && device_in_reset_o && !link_fund_reset_o;
  endsequence
  sequence proc_s;
    link_fund_reset_o [*4] ##[1:8] !link_fund_reset_o;
  endsequence
  a_ready_in_access: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready in access phase");
  a_unmapped_err: assert property (psel_i && penable_i && paddr_i > OFF_PORT_RESET
    |-> pslverr_o && prdata_o == 32'h0) else $error("unmapped access not refused");
  a_eeprom_addr_form: assert property (!link_fund_reset_o
    |-> eeprom_bus_addr_o[6:5] == 2'b10 && !eeprom_bus_addr_o[0]) else $error("eeprom addr");
  a_slave_addr_form: assert property (!link_fund_reset_o
    |-> slave_bus_addr_o[6] && slave_bus_addr_o[4] && !slave_bus_addr_o[0])
    else $error("slave addr");
  a_tick_period: assert property (master_bus_tick_o && seen_r
    |-> gap_r == (master_bus_slow_strap_i ? SLOW_DIV : FAST_DIV)) else $error("tick period");
  a_aux_power_off: assert property (!aux_power_disable_n_i |=> !aux_power_en_o)
    else $error("aux power used while disabled");
  a_fund_reset_seq: assert property ($rose(resetn_i) |-> proc_s)
    else $error("reset procedure length");
  a_link_in_reset: assert property (link_fund_reset_o |-> device_in_reset_o)
    else $error("running during reset procedure");
  a_halt_release: assert property (halt_clear_s |-> ##[1:3] !device_in_reset_o)
    else $error("halt clear did not release");
endmodule
bind switch_strap_reset_control strap_reset_monitor i_mon (.mclk_i, .resetn_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
  .master_bus_slow_strap_i, .aux_power_disable_n_i, .eeprom_bus_addr_o, .slave_bus_addr_o,
  .master_bus_tick_o, .aux_power_en_o, .link_fund_reset_o, .device_in_reset_o);
`default_nettype wire

// ### testbench/board_model.sv
// Board model: pull-ups, expander interrupt lines and host wake line
`timescale 1ns/1ps
`default_nettype none
module board_model (
  input  wire logic [10:0] pin_out_i,
  input  wire logic [10:0] pin_oe_i,
  input  wire logic        wake_out_i,
  input  wire logic        wake_oe_i,
  input  wire logic [2:0]  exp_irq_n_i,
  input  wire logic        host_wake_n_i,
  output logic      [10:0] pin_lvl_o,
  output logic             wake_lvl_o
);
  // Expanders pull pins 2..4 low (open drain); idle pins rest on pull-ups
  logic [10:0] ext;
  assign ext        = {6'h3F, exp_irq_n_i, 2'h3};
  assign pin_lvl_o  = (pin_out_i | ~pin_oe_i) & ext;
  assign wake_lvl_o = (wake_out_i | ~wake_oe_i) & host_wake_n_i;
endmodule
`default_nettype wire

// ### testbench/tb_switch_strap_reset_control.sv
// Testbench: register-level tests of the strap and reset block
`timescale 1ns/1ps
`default_nettype none
module tb_switch_strap_reset_control
  import strap_reset_pkg::*;
;
  logic        mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, wk_o, wk_oe, wk_i, tick, eeload, rsvd, auxen, fund, inrst, irq;
  logic [10:0] gpo, gpoe, gpi;
  logic [6:0]  eaddr, saddr;
  logic        auxn = 1, hwake = 1;
  logic [2:0]  expn = 3'h7;
  straps_s     st = '{4'hA, 4'h5, 3'h1, 1'b1, 1'b1, 1'b0, 1'b1};
  int          mismatches = 0, compares = 0, n;

  always #2 mclk = ~mclk;

  switch_strap_reset_control #(.PROC_CYC(4)) i_dut (.mclk_i(mclk), .resetn_i(resetn),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .eeprom_addr_strap_i(st.eeprom_addr), .slave_bus_addr_strap_i(st.slave_addr),
    .switch_mode_strap_i(st.mode), .master_bus_slow_strap_i(st.slow),
    .common_clock_downstream_strap_i(st.cclk_ds), .common_clock_upstream_strap_i(st.cclk_us),
    .reset_hold_request_i(st.hold), .aux_power_disable_n_i(auxn), .wake_pin_n_i(wk_i),
    .wake_pin_n_o(wk_o), .wake_pin_n_oe_o(wk_oe), .gpio_i(gpi), .gpio_o(gpo),
    .gpio_oe_o(gpoe), .eeprom_bus_addr_o(eaddr), .slave_bus_addr_o(saddr),
    .master_bus_tick_o(tick), .eeprom_load_o(eeload), .mode_reserved_o(rsvd),
    .aux_power_en_o(auxen), .link_fund_reset_o(fund), .device_in_reset_o(inrst),
    .irq_o(irq));

  board_model i_board (.pin_out_i(gpo), .pin_oe_i(gpoe), .wake_out_i(wk_o),
    .wake_oe_i(wk_oe), .exp_irq_n_i(expn), .host_wake_n_i(hwake), .pin_lvl_o(gpi),
    .wake_lvl_o(wk_i));

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q   = prdata;
    err = pslverr;
    if (k == 20) chk(0, 1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  task automatic do_reset(input logic [2:0] m, input logic h);
    st.mode <= m;
    st.hold <= h;
    resetn  <= 1'b0;
    repeat (10) @(posedge mclk);
    chk({fund, gpoe}, {1'b1, 11'h000});
    resetn <= 1'b1;
    n = 0;
    while (fund !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic give_verdict;
    $display("Counts: compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    give_verdict;
  end

  initial begin
    do_reset(3'h1, 1'b1);
    chk(eaddr, {2'b10, 4'hA, 1'b0});
    chk(saddr, {1'b1, 1'b0, 1'b1, 3'h5, 1'b0});
    st.eeprom_addr <= 4'h3;
    repeat (20) @(posedge mclk);
    chk({inrst, eaddr}, {1'b1, 2'b10, 4'hA, 1'b0});
    rd(OFF_STRAP_STAT, 32'h01F70F0F, 32'h0131050A);
    apb(1'b1, OFF_SWITCH_CTL, 32'h0);
    repeat (2) @(posedge mclk);
    chk(inrst, 1'b0);
    $display("Test straps and hold done");
    rd(OFF_LINK_STAT_US, 32'h1000, 32'h0000);
    rd(OFF_LINK_STAT_DS, 32'hF000, 32'hF000);
    apb(1'b1, OFF_LINK_STAT_US, 32'h1000);
    apb(1'b1, OFF_LINK_STAT_DS, 32'h5000);
    rd(OFF_LINK_STAT_US, 32'h1000, 32'h1000);
    rd(OFF_LINK_STAT_DS, 32'hF000, 32'h5000);
    $display("Test slot clock done");
    apb(1'b1, OFF_GPIO_DIR, 32'h7FF);
    apb(1'b1, OFF_GPIO_OUT, 32'h2A5);
    repeat (2) @(posedge mclk);
    chk({gpoe, gpo}, {11'h7FF, 11'h2A5});
    rd(OFF_GPIO_IN, 32'h7FF, 32'h2A5);
    apb(1'b1, OFF_GPIO_DIR, 32'h0);
    repeat (4) @(posedge mclk);
    rd(OFF_GPIO_IN, 32'h7FF, 32'h7FF);
    $display("Test gpio done");
    apb(1'b1, OFF_GPIO_DIR, 32'h7FF);
    apb(1'b1, OFF_GPIO_ALT, 32'h69F);
    apb(1'b1, OFF_SWITCH_CTL, 32'h2);
    apb(1'b1, OFF_PORT_RESET, 32'h5);
    repeat (2) @(posedge mclk);
    chk(gpo & 11'h7E3, 11'h422);
    chk(gpoe, 11'h7E3);
    $display("Test alternate pins done");
    expn <= 3'h6;
    repeat (4) @(posedge mclk);
    chk(irq, 1'b0);
    rd(OFF_IRQ_STAT, 32'h1, 32'h1);
    apb(1'b1, OFF_IRQ_EN, 32'h1);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    expn <= 3'h7;
    repeat (4) @(posedge mclk);
    apb(1'b1, OFF_IRQ_CLR, 32'h1);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    rd(OFF_IRQ_STAT, 32'h1, 32'h0);
    $display("Test interrupts done");
    apb(1'b1, OFF_WAKE_CTL, 32'h3);
    repeat (2) @(posedge mclk);
    chk({wk_oe, wk_o}, 2'b10);
    apb(1'b1, OFF_WAKE_CTL, 32'h0);
    hwake <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(wk_oe, 1'b0);
    rd(OFF_WAKE_CTL, 32'h2, 32'h2);
    hwake <= 1'b1;
    $display("Test wake done");
    apb(1'b1, 8'h40, 32'hFFFF);
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    chk(err, 1'b1);
    auxn <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(auxen, 1'b0);
    auxn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(auxen, 1'b1);
    $display("Test unmapped and aux done");
    n = 0;
    while (tick !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    n = 0;
    while (tick !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk(n + 1, SLOW_DIV);
    $display("Test bus rate done");
    for (int m = 0; m < 8; m++) begin
      do_reset(m[2:0], 1'b0);
      repeat (3) @(posedge mclk);
      chk({inrst, eeload, rsvd}, {1'b0, m == 1, m >= 2});
    end
    $display("Test mode codes done");
    give_verdict;
  end
endmodule
`default_nettype wire
